// *** tmr0_pkg.sv ***
// package: constants for the timer0 counter unit
package tmr0_pkg;
  localparam int TMR0_WIDTH = 8;
  localparam logic [7:0] TMR0_BOTTOM = 8'h00;
  localparam logic [7:0] TMR0_MAX = 8'hff;
  localparam logic [7:0] TMR0_CNT_RST = 8'h00;
  // clock select codes
  localparam logic [2:0] TMR0_CS_STOP = 3'h0;
  localparam logic [2:0] TMR0_CS_DIRECT = 3'h1;
  localparam logic [2:0] TMR0_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TMR0_CS_EXT_RISE = 3'h7;
  // waveform modes
  localparam logic [2:0] TMR0_WGM_NORMAL = 3'h0;
  localparam logic [2:0] TMR0_WGM_PC_MAX = 3'h1;
  localparam logic [2:0] TMR0_WGM_CTC = 3'h2;
  localparam logic [2:0] TMR0_WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] TMR0_WGM_PC_OCRA = 3'h5;
  localparam logic [2:0] TMR0_WGM_FAST_OCRA = 3'h7;
  // flag and mask bit positions
  localparam int TMR0_BIT_OVF = 0;
  localparam int TMR0_BIT_CMPA = 1;
  localparam int TMR0_BIT_CMPB = 2;
  // prescaler taps for clock select 2..5
  localparam int TMR0_DIV_8 = 8;
  localparam int TMR0_DIV_64 = 64;
  localparam int TMR0_DIV_256 = 256;
  localparam int TMR0_DIV_1024 = 1024;
endpackage

// *** tmr0_tick.sv ***
// tick generator: prescaler taps and synchronised external edge select
`timescale 1ns/1ps
module tmr0_tick (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [2:0] clock_select_field,
  input wire logic external_count_pin,
  output logic timer_tick
);
  import tmr0_pkg::*;

  typedef struct packed {
    logic [9:0] pre;
    logic [2:0] sync;
    logic tick;
  } tmr0_tick_s;

  tmr0_tick_s st;
  tmr0_tick_s next_st;

  // prescaler free-runs; a tap fires when its low bits wrap to zero
  always_comb begin
    next_st = st;
    next_st.pre = st.pre + 10'h001;
    // sync[0] only feeds sync[1]; edges are seen between sync[1] and sync[2]
    next_st.sync = {st.sync[1:0], external_count_pin};
    case (clock_select_field)
      3'h0: next_st.tick = 1'b0;
      3'h1: next_st.tick = 1'b1;
      3'h2: next_st.tick = (st.pre[2:0] == 3'h7);
      3'h3: next_st.tick = (st.pre[5:0] == 6'h3f);
      3'h4: next_st.tick = (st.pre[7:0] == 8'hff);
      3'h5: next_st.tick = (st.pre == 10'h3ff);
      3'h6: next_st.tick = st.sync[2] & ~st.sync[1];
      3'h7: next_st.tick = ~st.sync[2] & st.sync[1];
      default: next_st.tick = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign timer_tick = st.tick;

  stopped_no_tick_a: assert property (@(posedge mclk) disable iff (!arst_n)
    $past(clock_select_field) == TMR0_CS_STOP |-> !timer_tick)
    else $error("tick while stopped");
endmodule

// *** tmr0_core.sv ***
// timer0 counter unit: counter, compare units, flags and masks
`timescale 1ns/1ps
// Behaviour
// - counter and both compare registers are eight bits wide.
// - overflow and compare requests land in one flag register, each masked.
// - tick comes from prescaled clock or external pin, edge selectable.
// - clock select zero gives no tick, counter stops.
// - processor may read and write the counter anytime.
// - processor write to counter beats clear or count.
// - each tick clears, increments or decrements by exactly one.
// - bottom flags counter at 0x00, max flags counter at 0xff.
// - top is 0xff or compare register a, by mode.
// - both compare registers checked continuously; equality raises compare flag.
// - mode comes from two bits in control a, one in control b.
// - overflow flag set where the selected mode defines.
// - mode zero counts up, wraps, sets overflow as counter becomes zero.
// - mode two clears counter on match with compare register a.
// - compare flag set one tick after match; cleared by ack or write-one.
// - counter write blocks compare match in the next tick, even stopped.
module tmr0_core (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [2:0] clock_select_field,
  input wire logic waveform_mode_bit0,
  input wire logic waveform_mode_bit1,
  input wire logic waveform_mode_bit2,
  input wire logic external_count_pin,
  input wire logic counter_write,
  input wire logic [tmr0_pkg::TMR0_WIDTH-1:0] counter_wdata,
  input wire logic compare_a_write,
  input wire logic compare_b_write,
  input wire logic [tmr0_pkg::TMR0_WIDTH-1:0] compare_wdata,
  input wire logic [2:0] flag_clear,
  input wire logic [2:0] interrupt_taken,
  input wire logic mask_write,
  input wire logic [2:0] mask_wdata,
  output logic [tmr0_pkg::TMR0_WIDTH-1:0] counter_value,
  output logic [tmr0_pkg::TMR0_WIDTH-1:0] compare_value_a,
  output logic [tmr0_pkg::TMR0_WIDTH-1:0] compare_value_b,
  output logic [2:0] timer_flag_register,
  output logic [2:0] timer_mask_register,
  output logic [2:0] interrupt_request,
  output logic at_bottom,
  output logic at_max,
  output logic at_top
);
  import tmr0_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] cmpa;
    logic [7:0] cmpb;
    logic [2:0] flags;
    logic [2:0] mask;
    logic [2:0] irq;
    logic down;
    logic blk;
    logic pend_a;
    logic pend_b;
    logic bot;
    logic mx;
    logic tp;
  } tmr0_core_s;

  tmr0_core_s st;
  tmr0_core_s next_st;
  logic timer_tick;
  logic [2:0] mode;
  logic [7:0] top_val;
  logic match_a;
  logic match_b;
  logic ovf_evt;

  // mode bits split across two control registers
  assign mode = {waveform_mode_bit2, waveform_mode_bit1, waveform_mode_bit0};

  // ocra-topped modes use compare register a as the period
  function automatic logic top_is_ocra(input logic [2:0] m);
    top_is_ocra = (m == TMR0_WGM_CTC) || (m == TMR0_WGM_PC_OCRA) || (m == TMR0_WGM_FAST_OCRA);
  endfunction

  function automatic logic is_phase_correct(input logic [2:0] m);
    is_phase_correct = (m == TMR0_WGM_PC_MAX) || (m == TMR0_WGM_PC_OCRA);
  endfunction

  tmr0_tick u_tick (
    .mclk(mclk),
    .arst_n(arst_n),
    .clock_select_field(clock_select_field),
    .external_count_pin(external_count_pin),
    .timer_tick(timer_tick)
  );

  assign top_val = top_is_ocra(mode) ? st.cmpa : TMR0_MAX;
  // comparator runs every cycle; blocked for one tick after a counter write
  assign match_a = (st.cnt == st.cmpa) && !st.blk;
  assign match_b = (st.cnt == st.cmpb) && !st.blk;

  // next state: counter, direction, compare pipeline, flags
  always_comb begin
    next_st = st;
    ovf_evt = 1'b0;
    if (timer_tick) begin
      // match seen this tick sets the flag on the next tick edge
      next_st.pend_a = match_a;
      next_st.pend_b = match_b;
      next_st.blk = 1'b0;
      if (is_phase_correct(mode)) begin
        if (!st.down && st.cnt == top_val) begin
          next_st.down = 1'b1;
          next_st.cnt = st.cnt - 8'h01;
        end else if (st.down && st.cnt == TMR0_BOTTOM) begin
          next_st.down = 1'b0;
          next_st.cnt = st.cnt + 8'h01;
        end else if (st.down) begin
          next_st.cnt = st.cnt - 8'h01;
          ovf_evt = (st.cnt == 8'h01);
        end else begin
          next_st.cnt = st.cnt + 8'h01;
        end
      end else begin
        next_st.down = 1'b0;
        if (mode != TMR0_WGM_NORMAL && st.cnt == top_val) begin
          next_st.cnt = TMR0_BOTTOM;
          ovf_evt = (mode != TMR0_WGM_CTC);
        end else begin
          next_st.cnt = st.cnt + 8'h01;
          ovf_evt = (st.cnt == TMR0_MAX);
        end
      end
    end
    // processor write overrides any count or clear
    if (counter_write) begin
      next_st.cnt = counter_wdata;
      next_st.blk = 1'b1;
    end
    if (compare_a_write) begin
      next_st.cmpa = compare_wdata;
    end
    if (compare_b_write) begin
      next_st.cmpb = compare_wdata;
    end
    if (mask_write) begin
      next_st.mask = mask_wdata;
    end
    // set wins over clear so no event is lost
    next_st.flags = st.flags & ~(flag_clear | interrupt_taken);
    if (ovf_evt) begin
      next_st.flags[TMR0_BIT_OVF] = 1'b1;
    end
    if (timer_tick && st.pend_a) begin
      next_st.flags[TMR0_BIT_CMPA] = 1'b1;
    end
    if (timer_tick && st.pend_b) begin
      next_st.flags[TMR0_BIT_CMPB] = 1'b1;
    end
    next_st.irq = next_st.flags & next_st.mask;
    next_st.bot = (next_st.cnt == TMR0_BOTTOM);
    next_st.mx = (next_st.cnt == TMR0_MAX);
    next_st.tp = (next_st.cnt == (top_is_ocra(mode) ? next_st.cmpa : TMR0_MAX));
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.bot <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // all outputs straight from the state register
  assign counter_value = st.cnt;
  assign compare_value_a = st.cmpa;
  assign compare_value_b = st.cmpb;
  assign timer_flag_register = st.flags;
  assign timer_mask_register = st.mask;
  assign interrupt_request = st.irq;
  assign at_bottom = st.bot;
  assign at_max = st.mx;
  assign at_top = st.tp;

  write_priority_a: assert property (@(posedge mclk) disable iff (!arst_n)
    counter_write |=> counter_value == $past(counter_wdata))
    else $error("counter write lost");
  normal_wrap_a: assert property (@(posedge mclk) disable iff (!arst_n)
    timer_tick && !counter_write && mode == TMR0_WGM_NORMAL && counter_value == 8'hff
    |=> counter_value == 8'h00 && timer_flag_register[0])
    else $error("normal wrap or overflow wrong");
  count_step_a: assert property (@(posedge mclk) disable iff (!arst_n)
    timer_tick && !counter_write && mode == TMR0_WGM_NORMAL
    |=> counter_value == $past(counter_value) + 8'h01)
    else $error("count step not one");
  stop_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !timer_tick && !counter_write |=> $stable(counter_value))
    else $error("counter moved without tick");
  ctc_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
    timer_tick && !counter_write && mode == TMR0_WGM_CTC && counter_value == compare_value_a
    |=> counter_value == 8'h00)
    else $error("ctc did not clear");
  block_match_a: assert property (@(posedge mclk) disable iff (!arst_n)
    timer_tick && st.blk |=> !st.pend_a && !st.pend_b)
    else $error("match not blocked");
  block_arm_a: assert property (@(posedge mclk) disable iff (!arst_n)
    counter_write |=> st.blk)
    else $error("counter write did not arm blocking");
  bottom_max_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (at_bottom == (counter_value == 8'h00)) && (at_max == (counter_value == 8'hff)))
    else $error("bottom or max wrong");
  irq_mask_a: assert property (@(posedge mclk) disable iff (!arst_n)
    interrupt_request == (timer_flag_register & timer_mask_register))
    else $error("masked request wrong");
  flag_a_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
    timer_tick && st.pend_a |=> timer_flag_register[TMR0_BIT_CMPA])
    else $error("compare flag a not set one tick after match");
  flag_b_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
    timer_tick && st.pend_b |=> timer_flag_register[TMR0_BIT_CMPB])
    else $error("compare flag b not set one tick after match");
  pc_turn_a: assert property (@(posedge mclk) disable iff (!arst_n)
    timer_tick && !counter_write && mode == TMR0_WGM_PC_OCRA && !st.down
    && counter_value == compare_value_a |=> counter_value == $past(counter_value) - 8'h01)
    else $error("phase correct did not turn at top");
  fast_wrap_a: assert property (@(posedge mclk) disable iff (!arst_n)
    timer_tick && !counter_write && mode == TMR0_WGM_FAST_OCRA && counter_value == compare_value_a
    |=> counter_value == 8'h00 && timer_flag_register[TMR0_BIT_OVF])
    else $error("fast mode wrap or overflow wrong");
endmodule

// *** tmr0_bench.sv ***
// self-checking bench for the timer0 counter unit
`timescale 1ns/1ps
module tmr0_bench;
  import tmr0_pkg::*;
  logic mclk, arst_n, ext, cw, caw, cbw, mw, wm0, wm1, wm2, bot, mx, tp, m_blk;
  logic m_pa, m_pb, m_tick, up, seen0;
  logic [2:0] cs, fclr, itak, mwd, flg, msk, irq, m_flg, m_msk, m_cs;
  logic [7:0] cwd, pwd, cnt, oca, ocb, m_cnt, m_a, m_b, prv;
  int errors, n_checks, seed, k, i;
  tmr0_core dut (.mclk(mclk), .arst_n(arst_n), .clock_select_field(cs),
    .waveform_mode_bit0(wm0), .waveform_mode_bit1(wm1), .waveform_mode_bit2(wm2),
    .external_count_pin(ext), .counter_write(cw), .counter_wdata(cwd),
    .compare_a_write(caw), .compare_b_write(cbw), .compare_wdata(pwd),
    .flag_clear(fclr), .interrupt_taken(itak), .mask_write(mw), .mask_wdata(mwd),
    .counter_value(cnt), .compare_value_a(oca), .compare_value_b(ocb),
    .timer_flag_register(flg), .timer_mask_register(msk), .interrupt_request(irq),
    .at_bottom(bot), .at_max(mx), .at_top(tp));
  // free-running system clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic summarize();
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_cnt(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flg(input logic [2:0] got, input logic [2:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait for a counter value; running out ends the run
  task automatic wait_cnt(input logic [7:0] v);
    for (int j = 0; j < 600; j++) begin
      @(negedge mclk);
      if (cnt === v) return;
    end
    errors++;
    summarize();
  endtask
  // model advances on the rising edge; clears go first so a set in the same cycle wins
  // the tick lags the clock select by one edge; a match arms a pending bit and
  // the compare flag follows on the next tick
  task automatic step();
    @(posedge mclk);
    m_tick = (m_cs == TMR0_CS_DIRECT);
    m_cs = cs;
    m_flg = m_flg & ~(fclr | itak);
    if (m_tick) begin
      if (m_pa) m_flg[TMR0_BIT_CMPA] = 1'b1;
      if (m_pb) m_flg[TMR0_BIT_CMPB] = 1'b1;
      m_pa = !m_blk && m_cnt == m_a;
      m_pb = !m_blk && m_cnt == m_b;
      m_cnt = m_cnt + 8'h01;
      if (m_cnt == TMR0_BOTTOM) m_flg[TMR0_BIT_OVF] = 1'b1;
      m_blk = 1'b0;
    end
    // the write overrides the count but a tick in the same cycle still ran its compare
    if (cw) begin
      m_cnt = cwd;
      m_blk = 1'b1;
    end
    if (caw) m_a = pwd;
    if (cbw) m_b = pwd;
    if (mw) m_msk = mwd;
    @(negedge mclk);
  endtask
  task automatic check_all();
    chk_cnt(cnt, m_cnt);
    chk_flg(flg, m_flg);
    chk_flg(irq, m_flg & m_msk);
    chk_flg({bot, mx, tp}, {m_cnt == TMR0_BOTTOM, m_cnt == TMR0_MAX, m_cnt == TMR0_MAX});
    chk_cnt(oca, m_a);
    chk_cnt(ocb, m_b);
    chk_flg(msk, m_msk);
  endtask
  // main sequence: reset, random normal-mode runs, blocking, ctc, external pin
  initial begin
    seed = 32'hd001;
    errors = 0;
    n_checks = 0;
    {arst_n, ext, cw, caw, cbw, mw, wm0, wm1, wm2, m_blk, m_pa, m_pb, m_tick} = '0;
    {cs, fclr, itak, mwd, m_flg, m_msk, m_cs} = '0;
    {cwd, pwd, m_cnt, m_a, m_b} = '0;
    repeat (8) @(negedge mclk);
    check_all();
    arst_n = 1'b1;
    mw = 1'b1;
    mwd = 3'($random(seed));
    cs = TMR0_CS_DIRECT;
    step();
    mw = 1'b0;
    for (k = 0; k < 6; k++) begin
      // compare values never equal the loaded count, so blocking stays out of play
      cwd = 8'($random(seed));
      caw = 1'b1;
      pwd = cwd ^ (8'($random(seed)) | 8'h01);
      step();
      {caw, cbw} = 2'b01;
      pwd = cwd ^ (8'($random(seed)) | 8'h02);
      step();
      {cbw, cw} = 2'b01;
      step();
      cw = 1'b0;
      fclr = 3'h7;
      step();
      for (i = 0; i < 300; i++) begin
        fclr = (i == 200) ? 3'($random(seed)) : 3'h0;
        itak = (i == 100) ? 3'($random(seed)) : 3'h0;
        step();
        check_all();
      end
      {fclr, itak} = '0;
    end
    cs = TMR0_CS_STOP;
    pwd = 8'h20;
    cwd = 8'h20;
    caw = 1'b1;
    repeat (3) step();
    {caw, cw} = 2'b01;
    fclr = 3'h7;
    step();
    {cw, fclr} = '0;
    for (i = 0; i < 10; i++) begin
      step();
      chk_cnt(cnt, 8'h20);
      chk_flg(flg & 3'h2, 3'h0);
    end
    cs = TMR0_CS_DIRECT;
    // a match left pending from before the stop may set the flag on the first tick;
    // clearing one edge later leaves only a wrongly unblocked match at 0x20 visible
    repeat (2) @(negedge mclk);
    fclr = 3'h2;
    @(negedge mclk);
    fclr = 3'h0;
    chk_cnt(cnt, 8'h22);
    chk_flg(flg & 3'h2, 3'h0);
    wait_cnt(8'h1f);
    wait_cnt(8'h22);
    chk_flg(flg & 3'h2, 3'h2);
    cs = TMR0_CS_STOP;
    {wm1, caw} = 2'b11;
    pwd = 8'h05;
    @(negedge mclk);
    {caw, cw} = 2'b01;
    cwd = 8'h00;
    fclr = 3'h7;
    @(negedge mclk);
    {cw, fclr} = '0;
    cs = TMR0_CS_DIRECT;
    wait_cnt(8'h01);
    prv = 8'h01;
    for (i = 0; i < 40; i++) begin
      @(negedge mclk);
      prv = (prv == 8'h05) ? 8'h00 : prv + 8'h01;
      chk_cnt(cnt, prv);
      chk_flg({1'b0, tp, flg[TMR0_BIT_OVF]}, {1'b0, prv == 8'h05, 1'b0});
    end
    cs = TMR0_CS_STOP;
    wm1 = 1'b0;
    @(negedge mclk);
    cw = 1'b1;
    @(negedge mclk);
    cw = 1'b0;
    cs = TMR0_CS_EXT_RISE;
    // four rising edges counted, then four falling edges after the switch;
    // the switch waits until the last fall has settled so it is not counted
    for (k = 0; k < 8; k++) begin
      repeat (6) @(negedge mclk);
      if (k == 4) cs = TMR0_CS_EXT_FALL;
      ext = 1'b1;
      repeat (6) @(negedge mclk);
      ext = 1'b0;
    end
    repeat (6) @(negedge mclk);
    chk_cnt(cnt, 8'h08);
    // phase correct, then fast mode, both topped by compare a (still 5)
    for (k = 0; k < 2; k++) begin
      cs = TMR0_CS_STOP;
      {wm2, wm1, wm0} = (k == 0) ? TMR0_WGM_PC_OCRA : TMR0_WGM_FAST_OCRA;
      cwd = 8'h00;
      @(negedge mclk);
      {cw, fclr} = 4'hf;
      @(negedge mclk);
      {cw, fclr} = '0;
      cs = TMR0_CS_DIRECT;
      wait_cnt(8'h01);
      {up, seen0} = 2'b10;
      prv = 8'h01;
      for (i = 0; i < 40; i++) begin
        @(negedge mclk);
        if (k == 1) begin
          prv = (prv == 8'h05) ? 8'h00 : prv + 8'h01;
        end else if (up) begin
          up = (prv != 8'h05);
          prv = up ? prv + 8'h01 : prv - 8'h01;
        end else begin
          up = (prv == 8'h00);
          prv = up ? prv + 8'h01 : prv - 8'h01;
        end
        seen0 = seen0 | (prv == 8'h00);
        chk_cnt(cnt, prv);
        chk_flg({1'b0, tp, flg[TMR0_BIT_OVF]}, {1'b0, prv == 8'h05, seen0});
      end
    end
    summarize();
  end
endmodule
